/* rtl/dacr_pkg.sv */
// Constants, carrier types and decode helpers of the dual converter register bank.
// Shared by the bank, its serial port and its output formatter.
package dacr_pkg;

  localparam logic [6:0] ADDR_POWER = 7'h00;
  localparam logic [6:0] ADDR_OUT_FORMAT = 7'h01;
  localparam logic [6:0] ADDR_DRV_POWER = 7'h02;
  localparam logic [6:0] ADDR_TIMING = 7'h03;
  localparam logic [6:0] ADDR_TERM_A = 7'h04;
  localparam logic [6:0] ADDR_TERM_B = 7'h05;
  localparam logic [6:0] ADDR_DIV_FMT = 7'h06;
  localparam logic [6:0] ADDR_RSVD = 7'h07;
  localparam logic [6:0] ADDR_COMMON_MODE = 7'h08;
  localparam logic [6:0] ADDR_RESET_STATUS = 7'h0A;
  localparam int NUM_REGS = 9;

  localparam logic [7:0] RST_POWER = 8'h03;
  localparam logic [7:0] RST_TIMING = 8'h80;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [NUM_REGS-1:0][7:0] REG_DEFAULTS = {RST_ZERO, RST_ZERO, RST_ZERO, RST_ZERO, RST_ZERO,
    RST_TIMING, RST_ZERO, RST_ZERO, RST_POWER};
  localparam logic [7:0] SOFT_RESET_KEY = 8'h5A;

  localparam logic [7:0] STATUS_BASE = 8'h04;
  localparam int ST_ROM_BUSY = 5;
  localparam int ST_ROM_OK = 4;
  localparam int ST_DLL = 0;

  localparam int NIB_AVG = 3;
  localparam int NIB_STBY = 2;
  localparam int NIB_B = 1;
  localparam int NIB_A = 0;
  localparam int FMT_REV_B = 4;
  localparam int FMT_REV_A = 3;
  localparam int FMT_BUS_SEL = 2;
  localparam int FMT_SINGLE = 1;
  localparam int DRV_PD_LO = 2;
  localparam int DRV_OR_OFF = 1;
  localparam int DRV_CLK_OFF = 0;
  localparam int TIM_SKIP = 7;
  localparam int TIM_HALF = 6;
  localparam int TIM_CLK_LO = 3;
  localparam int TIM_DATA_LO = 0;
  localparam int TERM_CLK_LO = 3;
  localparam int TERM_DATA_LO = 0;

  localparam logic [4:0] SER_HDR_LAST = 5'h07;
  localparam logic [4:0] SER_DATA_LAST = 5'h0F;
  localparam logic [4:0] SER_FULL = 5'h10;

  typedef enum logic [1:0] {
    DACR_PD = 2'b00,
    DACR_STBY = 2'b01,
    DACR_RUN = 2'b10
  } dacr_chan_e;

  typedef struct packed {
    dacr_chan_e chan_a_mode;
    dacr_chan_e chan_b_mode;
    logic average_mode;
    logic single_bus_mode;
    logic shared_bus_select;
    logic rev_a;
    logic rev_b;
    logic [1:0] pd_out_state;
    logic over_range_oe_n;
    logic output_clock_oe_n;
    logic aligner_skip;
    logic half_period_delay;
    logic [2:0] output_clock_offset;
    logic [2:0] output_data_offset;
    logic [2:0] chan_a_data_term;
    logic [2:0] chan_a_clock_term;
  } dacr_ctl_s;

  localparam dacr_ctl_s CTL_RESET = '{chan_a_mode: DACR_RUN, chan_b_mode: DACR_RUN, aligner_skip: 1'b1,
    default: '0};

  typedef struct packed {
    logic wr_tgl;
    logic rd_tgl;
    logic [6:0] addr;
    logic [7:0] data;
  } dacr_xfer_s;

  // Signed step count in two's complement; the reserved code falls back to nominal
  function automatic logic [2:0] dacr_offset(input logic [2:0] code);
    if (code == 3'h4) return 3'h0;
    if (code[2]) return 3'h0 - {1'b0, code[1:0]};
    return code;
  endfunction

  // Termination step 0..4; any code with the top bit set is the highest step
  function automatic logic [2:0] dacr_term(input logic [2:0] code);
    return code[2] ? 3'h4 : {1'b0, code[1:0]};
  endfunction

endpackage

/* rtl/dacr_ser.sv */
// Three-wire serial port of the register bank, on the link clock.
// Assumes select high between frames; rd_data is held steady by the system side well before it is sampled.
module dacr_ser
  import dacr_pkg::*;
(
  input wire logic link_sclk,
  input wire logic link_cs_n,
  input wire logic rst_n,
  input wire logic sdio_in,
  input wire logic [7:0] rd_data,
  output logic sdio_out,
  output logic sdio_oe_n,
  output dacr_xfer_s xfer
);

  typedef struct packed {
    logic [4:0] cnt;
    logic [14:0] sh;
    logic rw;
  } dacr_ser_st_s;

  dacr_ser_st_s f_q;
  dacr_ser_st_s f_d;
  dacr_xfer_s x_d;
  logic [7:0] out_q;
  logic oe_n_q;
  logic frame_clr_n;

  // Select high ends a frame even though the link clock stands still
  assign frame_clr_n = rst_n & ~link_cs_n;

  always_comb begin
    f_d = f_q;
    x_d = xfer;
    if (f_q.cnt != SER_FULL) begin
      f_d.cnt = f_q.cnt + 5'h01;
      f_d.sh = {f_q.sh[13:0], sdio_in};
    end
    if (f_q.cnt == SER_HDR_LAST) begin
      f_d.rw = f_q.sh[6];
      if (f_q.sh[6]) begin
        x_d.addr = {f_q.sh[5:0], sdio_in};
        x_d.rd_tgl = ~xfer.rd_tgl;
      end
    end
    if (f_q.cnt == SER_DATA_LAST && !f_q.rw) begin
      x_d.addr = f_q.sh[13:7];
      x_d.data = {f_q.sh[6:0], sdio_in};
      x_d.wr_tgl = ~xfer.wr_tgl;
    end
  end

  always_ff @(posedge link_sclk or negedge frame_clr_n) begin
    if (!frame_clr_n) begin
      f_q <= '0;
    end else begin
      f_q <= f_d;
    end
  end

  // Transfer holding words survive the frame end; only power-on clears them
  always_ff @(posedge link_sclk or negedge rst_n) begin
    if (!rst_n) begin
      xfer <= '0;
    end else begin
      xfer <= x_d;
    end
  end

  // Read data leaves on falling edges, first bit after the eighth rising edge
  always_ff @(negedge link_sclk or negedge frame_clr_n) begin
    if (!frame_clr_n) begin
      out_q <= '0;
      oe_n_q <= 1'b1;
    end else if (f_q.cnt == SER_HDR_LAST + 5'h01 && f_q.rw && oe_n_q) begin
      out_q <= rd_data;
      oe_n_q <= 1'b0;
    end else begin
      out_q <= {out_q[6:0], 1'b0};
    end
  end

  assign sdio_out = out_q[7];
  assign sdio_oe_n = oe_n_q;

endmodule

/* rtl/dacr_fmt.sv */
// Output formatter: dual, multiplexed or averaged buses, bit reversal, power-down pin states.
// Assumes samples arrive with a one-cycle strobe at most every other cycle.
module dacr_fmt
  import dacr_pkg::*;
#(
  parameter int SAMPLE_W = 10
)
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic sample_valid,
  input wire logic [SAMPLE_W-1:0] chan_a_sample,
  input wire logic [SAMPLE_W-1:0] chan_b_sample,
  input dacr_ctl_s ctl,
  output logic [SAMPLE_W-1:0] bus_a_data,
  output logic [SAMPLE_W-1:0] bus_b_data,
  output logic bus_a_oe_n,
  output logic bus_b_oe_n
);

  typedef struct packed {
    logic [SAMPLE_W-1:0] a;
    logic [SAMPLE_W-1:0] b;
    logic second;
    logic [SAMPLE_W-1:0] bus_a;
    logic [SAMPLE_W-1:0] bus_b;
    logic oe_n;
  } dacr_fmt_st_s;

  dacr_fmt_st_s q;
  dacr_fmt_st_s n;

  always_comb begin
    logic [SAMPLE_W:0] sum;
    logic [SAMPLE_W-1:0] va;
    logic [SAMPLE_W-1:0] vb;
    logic [SAMPLE_W-1:0] pick;
    logic off;
    n = q;
    sum = {1'b0, q.a} + {1'b0, q.b};
    off = ctl.chan_a_mode == DACR_PD && ctl.chan_b_mode == DACR_PD;
    va = q.a;
    vb = q.b;
    pick = (ctl.shared_bus_select ^ q.second) ? q.b : q.a;
    if (off) begin
      va = {SAMPLE_W{ctl.pd_out_state[1]}};
      vb = va;
    end else if (ctl.average_mode) begin
      va = ctl.shared_bus_select ? '0 : sum[SAMPLE_W:1];
      vb = ctl.shared_bus_select ? sum[SAMPLE_W:1] : '0;
    end else if (ctl.single_bus_mode) begin
      va = ctl.shared_bus_select ? '0 : pick;
      vb = ctl.shared_bus_select ? pick : '0;
    end
    if (ce) begin
      if (sample_valid) begin
        n.a = chan_a_sample;
        n.b = chan_b_sample;
      end
      n.second = !sample_valid;
      for (int i = 0; i < SAMPLE_W; i++) begin
        n.bus_a[i] = ctl.rev_a ? va[SAMPLE_W-1-i] : va[i];
        n.bus_b[i] = ctl.rev_b ? vb[SAMPLE_W-1-i] : vb[i];
      end
      n.oe_n = off && !ctl.pd_out_state[0];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign bus_a_data = q.bus_a;
  assign bus_b_data = q.bus_b;
  assign bus_a_oe_n = q.oe_n;
  assign bus_b_oe_n = q.oe_n;

endmodule

/* rtl/dacr_bank.sv */
// Control and status register bank of a dual-channel converter, with its serial port and output formatter.
// Assumes the serial port's link clock is slow against sys_clk (period of at least 40 ns).

// Behaviour
// - status bit 5 shows ROM load running
// - status bit 4 shows ROM loaded, checksum good
// - status bit 0 DLL lock; bit 2 one
// - power-on defaults 03h, 80h, else zero
// - power-select pin picks low or high nibble
// - channel-on bits choose run, standby, power-down
// - no channel on: standby or full power-down
// - averaging bit outputs (A+B)/2
// - averaging keeps both running unless both off
// - format bits 4,3 reverse B, A buses
// - format bit 1 selects single multiplexed bus
// - format bit 2 picks bus and order
// - power-down outputs: hi-z, low or high
// - bit 1 of 02h floats over-range output
// - bit 0 of 02h floats output clock
// - timing bit 7 bypasses data aligner
// - half-period delay, inhibited in multiplexed mode
// - bits 5:3 shift output clock in steps
// - bits 2:0 shift data; code 100 reserved
// - termination codes, 1xx gives highest step
// - writing 5Ah to 0Ah restores defaults
// - frame: rw bit, 7 address, 8 data
module dacr_bank
  import dacr_pkg::*;
#(
  parameter int SAMPLE_W = 10
)
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic link_sclk,
  input wire logic link_cs_n,
  input wire logic serial_data_io_in,
  output logic serial_data_io_out,
  output logic serial_data_io_oe_n,
  input wire logic power_select_pin,
  input wire logic rom_load_busy,
  input wire logic rom_load_ok,
  input wire logic dll_locked,
  input wire logic sample_valid,
  input wire logic [SAMPLE_W-1:0] chan_a_sample,
  input wire logic [SAMPLE_W-1:0] chan_b_sample,
  output logic [SAMPLE_W-1:0] bus_a_data,
  output logic [SAMPLE_W-1:0] bus_b_data,
  output logic bus_a_oe_n,
  output logic bus_b_oe_n,
  output dacr_ctl_s ctl
);

  typedef struct packed {
    logic [NUM_REGS-1:0][7:0] regs;
    logic [1:0] psel_s;
    logic [2:0] wr_s;
    logic [2:0] rd_s;
    logic [7:0] rd_hold;
    dacr_ctl_s ctl;
  } dacr_bank_st_s;

  localparam dacr_bank_st_s ST_RESET = '{regs: REG_DEFAULTS, psel_s: '0, wr_s: '0, rd_s: '0,
    rd_hold: '0, ctl: CTL_RESET};

  dacr_bank_st_s st_q;
  dacr_bank_st_s st_d;
  dacr_xfer_s xfer;
  dacr_ctl_s ctl_next;
  logic wr_fire;
  logic rd_fire;
  logic wr_mapped;
  logic soft_reset;
  logic [3:0] act_nib;
  logic [7:0] status_byte;
  logic [7:0] rd_byte;

  dacr_ser u_ser (
    .link_sclk(link_sclk),
    .link_cs_n(link_cs_n),
    .rst_n(rst_n),
    .sdio_in(serial_data_io_in),
    .rd_data(st_q.rd_hold),
    .sdio_out(serial_data_io_out),
    .sdio_oe_n(serial_data_io_oe_n),
    .xfer(xfer)
  );

  dacr_fmt #(
    .SAMPLE_W(SAMPLE_W)
  ) u_fmt (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .ce(ce),
    .sample_valid(sample_valid),
    .chan_a_sample(chan_a_sample),
    .chan_b_sample(chan_b_sample),
    .ctl(st_q.ctl),
    .bus_a_data(bus_a_data),
    .bus_b_data(bus_b_data),
    .bus_a_oe_n(bus_a_oe_n),
    .bus_b_oe_n(bus_b_oe_n)
  );

  // Toggle events from the link side; the transfer word is stable by the time they land
  assign wr_fire = st_q.wr_s[2] ^ st_q.wr_s[1];
  assign rd_fire = st_q.rd_s[2] ^ st_q.rd_s[1];

  // Reserved slot and holes in the map refuse writes
  assign wr_mapped = xfer.addr <= ADDR_COMMON_MODE && xfer.addr != ADDR_RSVD;
  assign soft_reset = xfer.addr == ADDR_RESET_STATUS && xfer.data == SOFT_RESET_KEY;

  // Pin passes two flops before the decode sees it
  assign act_nib = st_q.psel_s[1] ? st_q.regs[0][7:4] : st_q.regs[0][3:0];

  always_comb begin
    status_byte = STATUS_BASE;
    status_byte[ST_ROM_BUSY] = rom_load_busy;
    status_byte[ST_ROM_OK] = rom_load_ok;
    status_byte[ST_DLL] = dll_locked;
  end

  always_comb begin
    if (xfer.addr == ADDR_RESET_STATUS) begin
      rd_byte = status_byte;
    end else if (wr_mapped) begin
      rd_byte = st_q.regs[xfer.addr[3:0]];
    end else begin
      rd_byte = 8'h00;
    end
  end

  always_comb begin
    dacr_chan_e idle;
    logic [7:0] fmt;
    logic [7:0] drv;
    logic [7:0] tim;
    logic [7:0] term;
    fmt = st_q.regs[1];
    drv = st_q.regs[2];
    tim = st_q.regs[3];
    term = st_q.regs[4];
    ctl_next = st_q.ctl;
    idle = act_nib[NIB_STBY] ? DACR_STBY : DACR_PD;
    if (act_nib[NIB_AVG] && (act_nib[NIB_A] || act_nib[NIB_B])) begin
      ctl_next.chan_a_mode = DACR_RUN;
      ctl_next.chan_b_mode = DACR_RUN;
      ctl_next.average_mode = 1'b1;
    end else begin
      ctl_next.chan_a_mode = act_nib[NIB_A] ? DACR_RUN : idle;
      ctl_next.chan_b_mode = act_nib[NIB_B] ? DACR_RUN : idle;
      ctl_next.average_mode = 1'b0;
    end
    ctl_next.rev_a = fmt[FMT_REV_A];
    ctl_next.rev_b = fmt[FMT_REV_B];
    ctl_next.single_bus_mode = fmt[FMT_SINGLE];
    ctl_next.shared_bus_select = fmt[FMT_BUS_SEL];
    ctl_next.pd_out_state = drv[DRV_PD_LO+1:DRV_PD_LO];
    ctl_next.over_range_oe_n = drv[DRV_OR_OFF];
    ctl_next.output_clock_oe_n = drv[DRV_CLK_OFF];
    ctl_next.aligner_skip = tim[TIM_SKIP];
    ctl_next.half_period_delay = tim[TIM_HALF] && !fmt[FMT_SINGLE];
    ctl_next.output_clock_offset = dacr_offset(tim[TIM_CLK_LO+2:TIM_CLK_LO]);
    ctl_next.output_data_offset = dacr_offset(tim[TIM_DATA_LO+2:TIM_DATA_LO]);
    ctl_next.chan_a_data_term = dacr_term(term[TERM_DATA_LO+2:TERM_DATA_LO]);
    ctl_next.chan_a_clock_term = dacr_term(term[TERM_CLK_LO+2:TERM_CLK_LO]);
  end

  always_comb begin
    st_d = st_q;
    if (ce) begin
      st_d.psel_s = {st_q.psel_s[0], power_select_pin};
      st_d.wr_s = {st_q.wr_s[1:0], xfer.wr_tgl};
      st_d.rd_s = {st_q.rd_s[1:0], xfer.rd_tgl};
      if (wr_fire) begin
        if (soft_reset) begin
          st_d.regs = REG_DEFAULTS;
        end else if (wr_mapped) begin
          // Format bits that must be zero are stored as written
          st_d.regs[xfer.addr[3:0]] = xfer.data;
        end
      end
      // Loaded long before the next falling link edge, so the port can sample it directly
      if (rd_fire) begin
        st_d.rd_hold = rd_byte;
      end
      st_d.ctl = ctl_next;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= ST_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  assign ctl = st_q.ctl;

  default clocking cb @(posedge sys_clk);
  endclocking

  default disable iff (!rst_n);

  property p_status;
    ce && rd_fire && xfer.addr == ADDR_RESET_STATUS |=> st_q.rd_hold ==
      {2'h0, $past(rom_load_busy), $past(rom_load_ok), 3'h2, $past(dll_locked)};
  endproperty
  a_status: assert property (p_status) else $error("status byte mismatch");

  property p_soft_reset;
    ce && wr_fire && soft_reset |=> st_q.regs == REG_DEFAULTS;
  endproperty
  a_soft_reset: assert property (p_soft_reset) else $error("soft reset missed defaults");

  property p_write;
    ce && wr_fire && xfer.addr == ADDR_TIMING |=> st_q.regs[3] == $past(xfer.data);
  endproperty
  a_write: assert property (p_write) else $error("timing write not stored");

  property p_unmapped;
    ce && wr_fire && !wr_mapped && !soft_reset |=> $stable(st_q.regs);
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped write changed a register");

  property p_both_on;
    ce && act_nib[1:0] == 2'h3 |=> ctl.chan_a_mode == DACR_RUN && ctl.chan_b_mode == DACR_RUN;
  endproperty
  a_both_on: assert property (p_both_on) else $error("both channels should run");

  property p_one_on;
    ce && act_nib == 4'h1 ##1 ce |-> ctl.chan_a_mode == DACR_RUN && ctl.chan_b_mode == DACR_PD
      && !ctl.average_mode;
  endproperty
  a_one_on: assert property (p_one_on) else $error("single channel decode wrong");

  property p_full_off;
    ce && act_nib[2:0] == 3'h0 |=> ctl.chan_a_mode == DACR_PD && ctl.chan_b_mode == DACR_PD;
  endproperty
  a_full_off: assert property (p_full_off) else $error("complete power-down expected");

  property p_standby;
    ce && act_nib[2:0] == 3'h4 |=> ctl.chan_a_mode == DACR_STBY && ctl.chan_b_mode == DACR_STBY;
  endproperty
  a_standby: assert property (p_standby) else $error("standby expected");

  property p_average;
    ce && act_nib[3] && act_nib[1:0] != 2'h0 |=> ctl.average_mode && ctl.chan_a_mode == DACR_RUN
      && ctl.chan_b_mode == DACR_RUN;
  endproperty
  a_average: assert property (p_average) else $error("averaging mode not entered");

  property p_pin_select;
    ce [*3] ##0 $past(power_select_pin, 2) && $stable(st_q.regs[0]) |=>
      ctl.chan_a_mode == ((st_q.regs[0][4] || (st_q.regs[0][7] && st_q.regs[0][5])) ? DACR_RUN :
      (st_q.regs[0][6] ? DACR_STBY : DACR_PD));
  endproperty
  a_pin_select: assert property (p_pin_select) else $error("high nibble not applied");

  property p_half;
    ctl.half_period_delay |-> !ctl.single_bus_mode;
  endproperty
  a_half: assert property (p_half) else $error("half delay active in multiplexed mode");

  property p_offset;
    ctl.output_clock_offset != 3'h4 && ctl.output_data_offset != 3'h4;
  endproperty
  a_offset: assert property (p_offset) else $error("offset outside three steps");

  property p_drivers;
    ce |=> ctl.over_range_oe_n == $past(st_q.regs[2][1]) && ctl.output_clock_oe_n == $past(st_q.regs[2][0]);
  endproperty
  a_drivers: assert property (p_drivers) else $error("driver disable not applied");

  property p_term;
    ce && st_q.regs[4][2] |=> ctl.chan_a_data_term == 3'h4;
  endproperty
  a_term: assert property (p_term) else $error("termination top step wrong");

  property p_skip;
    ce |=> ctl.aligner_skip == $past(st_q.regs[3][7]);
  endproperty
  a_skip: assert property (p_skip) else $error("aligner bypass not applied");

  property p_chan_b_only;
    ce && act_nib == 4'h6 |=> ctl.chan_a_mode == DACR_STBY && ctl.chan_b_mode == DACR_RUN;
  endproperty
  a_chan_b_only: assert property (p_chan_b_only) else $error("channel B with A standby wrong");

  property p_stby_mix;
    ce && act_nib == 4'h5 |=> ctl.chan_a_mode == DACR_RUN && ctl.chan_b_mode == DACR_STBY;
  endproperty
  a_stby_mix: assert property (p_stby_mix) else $error("channel A with B standby wrong");

  property p_run_oe;
    ce && ctl.chan_a_mode == DACR_RUN |=> !bus_a_oe_n && !bus_b_oe_n;
  endproperty
  a_run_oe: assert property (p_run_oe) else $error("buses floated while running");

  property p_pd_drive;
    ce && ctl.chan_a_mode == DACR_PD && ctl.chan_b_mode == DACR_PD |=> bus_a_oe_n == !$past(ctl.pd_out_state[0]);
  endproperty
  a_pd_drive: assert property (p_pd_drive) else $error("power-down enable wrong");

  property p_pd_level;
    ce && ctl.chan_a_mode == DACR_PD && ctl.chan_b_mode == DACR_PD |=> bus_b_data == {SAMPLE_W{$past(ctl.pd_out_state[1])}};
  endproperty
  a_pd_level: assert property (p_pd_level) else $error("power-down level wrong");

  property p_single_zero;
    ce && ctl.single_bus_mode && !ctl.average_mode && ctl.chan_a_mode == DACR_RUN && ctl.shared_bus_select
      |=> bus_a_data == '0;
  endproperty
  a_single_zero: assert property (p_single_zero) else $error("unused bus not zero");

  property p_average_bus;
    ce && ctl.average_mode && !ctl.shared_bus_select
      |=> bus_b_data == '0;
  endproperty
  a_average_bus: assert property (p_average_bus) else $error("average on wrong bus");

  property p_fmt_store;
    ce && wr_fire && xfer.addr == ADDR_OUT_FORMAT |=> st_q.regs[1] == $past(xfer.data);
  endproperty
  a_fmt_store: assert property (p_fmt_store) else $error("format write not stored");

  property p_unmapped_read;
    ce && rd_fire && !wr_mapped && xfer.addr != ADDR_RESET_STATUS |=> st_q.rd_hold == 8'h00;
  endproperty
  a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read not zero");

  c_pd_float: cover property (bus_a_oe_n);
  c_soft_reset: cover property (ce && wr_fire && soft_reset);
  c_status_read: cover property (ce && rd_fire && xfer.addr == ADDR_RESET_STATUS);
  c_average: cover property (ctl.average_mode && ctl.single_bus_mode);
  c_standby: cover property (ctl.chan_a_mode == DACR_STBY && ctl.chan_b_mode == DACR_RUN);

endmodule

/* dv/dacr_host.sv */
// Host model of the three-wire serial port: one frame per call, sclk idle low between frames.
// Assumes the bench reads sdio_wire; a released line toggles so stale data cannot pass as a match.
module dacr_host (
  output logic link_sclk,
  output logic link_cs_n,
  input wire logic dev_out,
  input wire logic dev_oe_n,
  output logic sdio_wire
);
  timeunit 1ns;
  timeprecision 1ps;
  logic drv = 1'b0;
  logic en = 1'b0;
  logic flt = 1'b0;
  initial begin
    link_sclk = 1'b0;
    // Select starts low for a moment so the frame clear sees a falling edge at reset
    link_cs_n = 1'b0;
    #1 link_cs_n = 1'b1;
  end
  always #9.1 flt = ~flt;
  assign sdio_wire = !dev_oe_n ? dev_out : (en ? drv : flt);
  // Bits change while sclk is low, read bits are taken on the rise
  task automatic xfer(input logic rd, input logic [6:0] addr, input logic [7:0] wdat, output logic [7:0] rdat);
    logic [15:0] f;
    f = {rd, addr, wdat};
    rdat = 8'h00;
    #1.3 link_cs_n = 1'b0;
    en = 1'b1;
    for (int i = 15; i >= 0; i--) begin
      if (rd && i < 8) en = 1'b0;
      drv = f[i];
      #62.5 link_sclk = 1'b1;
      if (i < 8) rdat[i] = sdio_wire;
      #62.5 link_sclk = 1'b0;
    end
    #62.5 link_cs_n = 1'b1;
    en = 1'b0;
    #62.5;
  endtask
endmodule

/* dv/dacr_bank_tb.sv */
// Self-checking bench of the register bank: serial host model, sample stimulus, port checks.
// Assumes the handed-over write and read latencies; sys_clk 4 ns, link clock 125 ns.
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin errors++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module dacr_bank_tb
  import dacr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int W = 10;
  localparam logic [W-1:0] SA = 10'h301;
  localparam logic [W-1:0] SB = 10'h0F6;
  localparam logic [W:0] SUM = SA + SB;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b1;
  logic ce = 1'b1;
  logic power_select_pin = 1'b0;
  logic rom_load_busy = 1'b0;
  logic rom_load_ok = 1'b0;
  logic dll_locked = 1'b0;
  logic sample_valid = 1'b0;
  logic [W-1:0] chan_a_sample = '0;
  logic [W-1:0] chan_b_sample = '0;
  logic link_sclk, link_cs_n, sdio_wire, sdio_out, sdio_oe_n;
  logic [W-1:0] bus_a_data, bus_b_data;
  logic bus_a_oe_n, bus_b_oe_n;
  dacr_ctl_s ctl;
  int errors = 0;
  int n_tests = 0;
  always #2 sys_clk = ~sys_clk;
  dacr_bank #(.SAMPLE_W(W)) i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .ce(ce), .link_sclk(link_sclk),
    .link_cs_n(link_cs_n), .serial_data_io_in(sdio_wire), .serial_data_io_out(sdio_out),
    .serial_data_io_oe_n(sdio_oe_n), .power_select_pin(power_select_pin), .rom_load_busy(rom_load_busy),
    .rom_load_ok(rom_load_ok), .dll_locked(dll_locked), .sample_valid(sample_valid),
    .chan_a_sample(chan_a_sample), .chan_b_sample(chan_b_sample), .bus_a_data(bus_a_data),
    .bus_b_data(bus_b_data), .bus_a_oe_n(bus_a_oe_n), .bus_b_oe_n(bus_b_oe_n), .ctl(ctl));
  dacr_host i_host (.link_sclk(link_sclk), .link_cs_n(link_cs_n), .dev_out(sdio_out), .dev_oe_n(sdio_oe_n),
    .sdio_wire(sdio_wire));
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] r;
    i_host.xfer(1'b0, a, d, r);
    cyc(8);
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    logic [7:0] r;
    i_host.xfer(1'b1, a, 8'h00, r);
    `CHK(r, e)
    cyc(2);
  endtask
  task automatic chk_dflt();
    for (int a = 0; a < 9; a++) begin
      if (a != 7) rd(7'(a), a == 0 ? 8'h03 : (a == 3 ? 8'h80 : 8'h00));
    end
  endtask
  task automatic smp(input logic [W-1:0] a, input logic [W-1:0] b, input logic [2*W-1:0] e1,
    input logic [2*W-1:0] e2);
    @(posedge sys_clk);
    sample_valid <= 1'b1;
    chan_a_sample <= a;
    chan_b_sample <= b;
    @(posedge sys_clk);
    sample_valid <= 1'b0;
    @(posedge sys_clk);
    #1 `CHK({bus_a_data, bus_b_data}, e1)
    @(posedge sys_clk);
    #1 `CHK({bus_a_data, bus_b_data}, e2)
  endtask
  task automatic tdone(input string s);
    $display("test %s done, mismatches so far %0d", s, errors);
  endtask
  function automatic logic [W-1:0] rv(input logic [W-1:0] v);
    for (int i = 0; i < W; i++) rv[i] = v[W-1-i];
  endfunction
  function automatic logic [3:0] pw(input logic [3:0] n);
    logic [1:0] sb;
    sb = n[2] ? DACR_STBY : DACR_PD;
    if (n[3] && n[1:0] != 2'b00) return {DACR_RUN, DACR_RUN};
    return {n[0] ? DACR_RUN : sb, n[1] ? DACR_RUN : sb};
  endfunction
  // Reserved code 100 is never programmed, so it is not modelled
  function automatic logic [2:0] off(input logic [2:0] c);
    return c[2] ? 3'h0 - {1'b0, c[1:0]} : c;
  endfunction
  function automatic logic [2:0] tm(input logic [2:0] c);
    return c[2] ? 3'h4 : c;
  endfunction
  task automatic finish_test();
    $display("Counts: %0d comparisons, %0d mismatches", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Whole run is near 190 us; twice that means a hang
  initial begin
    #400us;
    errors++;
    finish_test();
  end
  // Reset falls after every process waits, so the link-side async flops see the edge
  initial begin
    rst_n <= 1'b0;
    cyc(3);
    rst_n <= 1'b1;
    cyc(4);
    `CHK(ctl, CTL_RESET)
    chk_dflt();
    rom_load_busy <= 1'b1;
    dll_locked <= 1'b1;
    rd(ADDR_RESET_STATUS, 8'h25);
    rom_load_busy <= 1'b0;
    rom_load_ok <= 1'b1;
    dll_locked <= 1'b0;
    rd(ADDR_RESET_STATUS, 8'h14);
    tdone("defaults_status");
    for (int a = 1; a < 9; a++) begin
      if (a != 7) wr(7'(a), {a[3:0], 4'hE});
    end
    for (int a = 1; a < 9; a++) begin
      if (a != 7) rd(7'(a), {a[3:0], 4'hE});
    end
    wr(7'h09, 8'hFF);
    rd(7'h09, 8'h00);
    rd(7'h0B, 8'h00);
    rd(ADDR_DRV_POWER, 8'h2E);
    wr(ADDR_RESET_STATUS, 8'h33);
    rd(ADDR_TERM_A, 8'h4E);
    wr(ADDR_RESET_STATUS, 8'h5A);
    chk_dflt();
    tdone("access");
    for (int n = 0; n < 16; n++) begin
      wr(ADDR_POWER, {4'(15 - n), 4'(n)});
      `CHK({ctl.chan_a_mode, ctl.chan_b_mode}, pw(4'(n)))
      power_select_pin <= 1'b1;
      cyc(4);
      `CHK({ctl.chan_a_mode, ctl.chan_b_mode}, pw(4'(15 - n)))
      power_select_pin <= 1'b0;
    end
    tdone("power");
    wr(ADDR_POWER, 8'h03);
    wr(ADDR_OUT_FORMAT, 8'h00);
    smp(SA, SB, {SA, SB}, {SA, SB});
    wr(ADDR_OUT_FORMAT, 8'h18);
    smp(SA, SB, {rv(SA), rv(SB)}, {rv(SA), rv(SB)});
    wr(ADDR_OUT_FORMAT, 8'h0A);
    smp(SA, SB, {rv(SA), 10'h000}, {rv(SB), 10'h000});
    wr(ADDR_OUT_FORMAT, 8'h06);
    smp(SA, SB, {10'h000, SB}, {10'h000, SA});
    wr(ADDR_POWER, 8'h09);
    wr(ADDR_OUT_FORMAT, 8'h04);
    smp(SA, SB, {10'h000, SUM[W:1]}, {10'h000, SUM[W:1]});
    wr(ADDR_POWER, 8'h0A);
    wr(ADDR_OUT_FORMAT, 8'h00);
    smp(SA, SB, {SUM[W:1], 10'h000}, {SUM[W:1], 10'h000});
    tdone("samples");
    for (int c = 0; c < 8; c++) begin
      if (c != 4) begin
        wr(ADDR_TIMING, {2'b01, 3'(c), 3'(8 - c)});
        `CHK({ctl.aligner_skip, ctl.half_period_delay, ctl.output_clock_offset, ctl.output_data_offset}, {2'b01, off(3'(c)), off(3'(8 - c))})
      end
    end
    wr(ADDR_TIMING, 8'hC0);
    wr(ADDR_OUT_FORMAT, 8'h02);
    `CHK({ctl.aligner_skip, ctl.half_period_delay}, 2'b10)
    for (int c = 0; c < 8; c++) begin
      wr(ADDR_TERM_A, {2'b11, 3'(c), 3'(7 - c)});
      `CHK({ctl.chan_a_clock_term, ctl.chan_a_data_term}, {tm(3'(c)), tm(3'(7 - c))})
    end
    tdone("timing_term");
    ce <= 1'b0;
    wr(ADDR_OUT_FORMAT, 8'h00);
    `CHK(ctl.single_bus_mode, 1'b1)
    ce <= 1'b1;
    cyc(8);
    `CHK(ctl.single_bus_mode, 1'b0)
    wr(ADDR_POWER, 8'h00);
    for (int p = 0; p < 4; p++) begin
      wr(ADDR_DRV_POWER, {4'h0, 2'(p), 2'(p)});
      cyc(2);
      `CHK({bus_a_oe_n, bus_b_oe_n, ctl.over_range_oe_n, ctl.output_clock_oe_n}, {{2{~p[0]}}, 2'(p)})
      if (p[0]) `CHK({bus_a_data, bus_b_data}, {2*W{p[1]}})
    end
    tdone("powerdown_pins");
    finish_test();
  end
endmodule
